// file: logic/gtlb_map.svh
// offsets, field positions, sizes and encodings for the guest tlb / cp0 block
`ifndef GTLB_MAP_SVH
`define GTLB_MAP_SVH
`define NENT       32
`define VSIZE      16
`define FWAYS      4
`define FWAY_BITS  2
`define IDXW       5
`define ASIDW      8
`define GIDW       8
`define CPAW       8
`define CP_DEPTH   256
`define CPDW       64
`define TE_W       18
`define TE_RST     18'h20000
`define ADDRW      8
`define OFF_CTRL   8'h00
`define OFF_EHI    8'h04
`define OFF_INDEX  8'h08
`define OFF_GPRLO  8'h0c
`define OFF_GPRHI  8'h10
`define OFF_INSTR  8'h14
`define OFF_STATUS 8'h18
`define OFF_TSEL   8'h1c
`define OFF_TWDATA 8'h20
`define OFF_TRDATA 8'h24
`define OFF_CSEL   8'h28
`define OFF_CRLO   8'h2c
`define OFF_CRHI   8'h30
`define CTRL_RST   32'h0000_0395
`define CTRL_MASK  32'h00ff_03ff
`define CTRL_CP0EN 0
`define CTRL_GK    1
`define CTRL_VZ    2
`define CTRL_G1    3
`define CTRL_TLB   4
`define CTRL_MT    7:5
`define CTRL_IE    9:8
`define CTRL_RID   23:16
`define ST_BUSY    0
`define ST_EXC     2:1
`define ST_GUEST   3
`define EXC_NONE   2'h0
`define EXC_RI     2'h1
`define EXC_CPU    2'h2
`define I_OP       31:26
`define I_CLS      25
`define I_ZERO     24:6
`define I_FN       5:0
`define I_RS       25:21
`define I_RD       15:11
`define I_SUB      10:3
`define I_SEL      2:0
`define OPC_SYSCTL 6'h10
`define FN_GINV    6'h0b
`define FN_GINVF   6'h0c
`define RS_MTGC    5'h03
`define MTGC_SUB   8'h40
`define Z19        19'h0
`define GINV_WORD  32'h4200_000b
`define MT_JOINT   3'h1
`define MT_VF      3'h4
`define IE_NONE    2'h0
`define IE_HW      2'h3
`endif

// file: logic/gtlb_pkg.sv
// shared types for the guest tlb / cp0 block
`include "gtlb_map.svh"
package gtlb_pkg;
  typedef struct packed {
    logic              inv;
    logic              g;
    logic [`GIDW-1:0]  gid;
    logic [`ASIDW-1:0] address_space_id;
  } tlb_entry_t;
  typedef struct packed {
    logic              go;
    logic              flush;
    logic              gid_chk;
    logic [`IDXW-1:0]  lo;
    logic [`IDXW-1:0]  hi;
    logic [`ASIDW-1:0] address_space_id;
    logic [`GIDW-1:0]  gid;
  } inv_req_t;
  typedef enum logic {ST_IDLE, ST_EXEC} state_t;
endpackage : gtlb_pkg

// file: logic/guest_cp0_mem.sv
// guest system-control register storage, registered read
`include "gtlb_map.svh"
module guest_cp0_mem (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [`CPAW-1:0] waddr,
  input  wire logic [`CPDW-1:0] wdata,
  input  wire logic [`CPAW-1:0] raddr,
  output logic      [`CPDW-1:0] rdata
);
  logic [`CPDW-1:0] mem_q [`CP_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule : guest_cp0_mem

// file: logic/guest_tlb_array.sv
// guest tlb tag array with parallel range invalidate
`include "gtlb_map.svh"
module guest_tlb_array (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 we,
  input  wire logic [`IDXW-1:0]     widx,
  input  gtlb_pkg::tlb_entry_t      wdata,
  input  wire logic [`IDXW-1:0]     ridx,
  input  gtlb_pkg::inv_req_t        req,
  output gtlb_pkg::tlb_entry_t      rdata
);
  gtlb_pkg::tlb_entry_t ent_q [`NENT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  for (genvar i = 0; i < `NENT; i++) begin : g_ent
    logic sel;
    logic hit;
    always_comb begin
      sel = req.go && (i >= int'(req.lo)) && (i <= int'(req.hi));
      hit = (req.flush || (ent_q[i].address_space_id == req.address_space_id && !ent_q[i].g))
            && (!req.gid_chk || ent_q[i].gid == req.gid);
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ent_q[i] <= gtlb_pkg::tlb_entry_t'(`TE_RST);
      end else if (sel && hit) begin
        ent_q[i].inv <= 1'b1;
      end else if (we && widx == `IDXW'(i)) begin
        ent_q[i] <= wdata;
      end
    end
    a_global_kept: assert property (
      (req.go && !req.flush && ent_q[i].g && !(we && widx == `IDXW'(i)))
      |=> $stable(ent_q[i]))
      else $error("global entry changed by address_space_id invalidate");
    a_gid_filter: assert property (
      (req.go && req.gid_chk && ent_q[i].gid != req.gid && !(we && widx == `IDXW'(i)))
      |=> $stable(ent_q[i]))
      else $error("entry of another guest invalidated");
    a_flush_range: assert property (
      (req.go && req.flush && i >= int'(req.lo) && i <= int'(req.hi)
       && (!req.gid_chk || ent_q[i].gid == req.gid)) |=> ent_q[i].inv)
      else $error("flush left an entry valid in range");
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= gtlb_pkg::tlb_entry_t'(`TE_RST);
    end else begin
      rdata <= ent_q[ridx];
    end
  end
endmodule : guest_tlb_array

// file: logic/guest_tlb_invalidate_and_cp0_write.sv
// root-mode guest cp0 write and guest tlb invalidate engine, ahb-lite slave
// Functional notes
// - write source value into addressed guest register
// - guest-kernel use raises guest reserved instruction
// - full sixty-four bit value is written
// - coprocessor disabled raises coprocessor unusable
// - decode exact invalidate opcode pattern
// - address_space_id invalidate spares global entries
// - wired boundary does not protect entries
// - joint tlb: all matches, index ignored
// - variable range all, fixed range one set
// - hardware walk covers whole array
// - guest identifier filter when supported
// - no guest tlb raises reserved instruction
// - capability field reports invalidate support
// - flush ignores address and address_space_id
// - joint tlb flush clears everything
// - flush clears variable array or one set
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`include "gtlb_map.svh"
module guest_tlb_invalidate_and_cp0_write (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata
);
  logic [31:0]          ctrl_q;
  logic [`ASIDW-1:0]    address_space_id_q;
  logic [`IDXW-1:0]     idx_q;
  logic [`CPDW-1:0]     gpr_q;
  logic [31:0]          instr_q;
  logic [`IDXW-1:0]     tlb_sel_q;
  logic [`CPAW-1:0]     cp0_sel_q;
  logic [1:0]           exc_q;
  logic                 exc_guest_q;
  gtlb_pkg::state_t     state_q;
  logic                 wr_pend_q;
  logic [`ADDRW-1:0]    addr_q;
  logic                 ap_take;
  logic                 dec_inv;
  logic                 dec_invf;
  logic                 dec_mtgc;
  logic                 tlb_ok;
  logic [2:0]           mt;
  logic [1:0]           ie;
  logic [1:0]           exc_d;
  logic                 guest_d;
  logic                 exec_ok;
  logic [`IDXW-1:0]     lo_d;
  logic [`IDXW-1:0]     hi_d;
  gtlb_pkg::inv_req_t   inv;
  gtlb_pkg::tlb_entry_t tlb_rdata;
  logic                 cp_we;
  logic [`CPAW-1:0]     cp_waddr;
  logic [`CPDW-1:0]     cp_rdata;
  logic [31:0]          rd_c;

  function automatic logic is_inv(input logic [31:0] w, input logic [5:0] fn);
    return w[`I_OP] == `OPC_SYSCTL && w[`I_CLS] && w[`I_ZERO] == `Z19 && w[`I_FN] == fn;
  endfunction : is_inv

  function automatic logic is_mtgc(input logic [31:0] w);
    return w[`I_OP] == `OPC_SYSCTL && w[`I_RS] == `RS_MTGC && w[`I_SUB] == `MTGC_SUB;
  endfunction : is_mtgc

  function automatic logic wr_sel(input logic [`ADDRW-1:0] off);
    return wr_pend_q && hreadyout && addr_q == off;
  endfunction : wr_sel

  assign ap_take = hsel && htrans[1] && hready;

  // bus address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= '0;
    end else if (hreadyout) begin
      wr_pend_q <= ap_take && hwrite;
      if (ap_take) begin
        addr_q <= haddr[`ADDRW-1:0];
      end
    end
  end

  // software-written registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= `CTRL_RST;
      address_space_id_q    <= '0;
      idx_q     <= '0;
      gpr_q     <= '0;
      instr_q   <= '0;
      tlb_sel_q <= '0;
      cp0_sel_q <= '0;
    end else begin
      if (wr_sel(`OFF_CTRL)) begin
        ctrl_q <= hwdata & `CTRL_MASK;
      end
      if (wr_sel(`OFF_EHI)) begin
        address_space_id_q <= hwdata[`ASIDW-1:0];
      end
      if (wr_sel(`OFF_INDEX)) begin
        idx_q <= hwdata[`IDXW-1:0];
      end
      if (wr_sel(`OFF_GPRLO)) begin
        gpr_q[31:0] <= hwdata;
      end
      if (wr_sel(`OFF_GPRHI)) begin
        gpr_q[`CPDW-1:32] <= hwdata;
      end
      if (wr_sel(`OFF_INSTR)) begin
        instr_q <= hwdata;
      end
      if (wr_sel(`OFF_TSEL)) begin
        tlb_sel_q <= hwdata[`IDXW-1:0];
      end
      if (wr_sel(`OFF_CSEL)) begin
        cp0_sel_q <= hwdata[`CPAW-1:0];
      end
    end
  end

  // decode, exception check and invalidate range
  always_comb begin
    dec_inv  = is_inv(instr_q, `FN_GINV);
    dec_invf = is_inv(instr_q, `FN_GINVF);
    dec_mtgc = is_mtgc(instr_q);
    mt       = ctrl_q[`CTRL_MT];
    ie       = ctrl_q[`CTRL_IE];
    tlb_ok   = ctrl_q[`CTRL_TLB] && (mt == `MT_JOINT || mt == `MT_VF) && ie != `IE_NONE;
    exc_d    = `EXC_NONE;
    guest_d  = 1'b0;
    if (!ctrl_q[`CTRL_CP0EN]) begin
      exc_d = `EXC_CPU;
    end else if (ctrl_q[`CTRL_GK]) begin
      exc_d   = `EXC_RI;
      guest_d = 1'b1;
    end else if (!ctrl_q[`CTRL_VZ]) begin
      exc_d = `EXC_RI;
    end else if ((dec_inv || dec_invf) && !tlb_ok) begin
      exc_d = `EXC_RI;
    end else if (!(dec_inv || dec_invf || dec_mtgc)) begin
      exc_d = `EXC_RI;
    end
    exec_ok = state_q == gtlb_pkg::ST_EXEC && exc_d == `EXC_NONE;
    lo_d    = '0;
    hi_d    = '1;
    if (mt == `MT_VF && ie != `IE_HW) begin
      if (idx_q < `IDXW'(`VSIZE)) begin
        hi_d = `IDXW'(`VSIZE - 1);
      end else begin
        lo_d = {idx_q[`IDXW-1:`FWAY_BITS], {`FWAY_BITS{1'b0}}};
        hi_d = {idx_q[`IDXW-1:`FWAY_BITS], {`FWAY_BITS{1'b1}}};
      end
    end
    inv.go      = exec_ok && (dec_inv || dec_invf);
    inv.flush   = dec_invf;
    inv.gid_chk = ctrl_q[`CTRL_G1];
    inv.lo      = lo_d;
    inv.hi      = hi_d;
    inv.address_space_id    = address_space_id_q;
    inv.gid     = ctrl_q[`CTRL_RID];
    cp_we       = exec_ok && dec_mtgc;
    cp_waddr    = {instr_q[`I_RD], instr_q[`I_SEL]};
  end

  // one-cycle execute, bus stalled meanwhile
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= gtlb_pkg::ST_IDLE;
      hreadyout <= 1'b1;
    end else begin
      unique case (state_q)
        gtlb_pkg::ST_IDLE: begin
          if (wr_sel(`OFF_INSTR)) begin
            state_q   <= gtlb_pkg::ST_EXEC;
            hreadyout <= 1'b0;
          end
        end
        gtlb_pkg::ST_EXEC: begin
          state_q   <= gtlb_pkg::ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // exception status of last instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exc_q       <= `EXC_NONE;
      exc_guest_q <= 1'b0;
    end else if (state_q == gtlb_pkg::ST_EXEC) begin
      exc_q       <= exc_d;
      exc_guest_q <= guest_d;
    end
  end

  guest_tlb_array u_tlb (
    .clk   (hclk),
    .rstn  (hresetn),
    .we    (wr_sel(`OFF_TWDATA)),
    .widx  (tlb_sel_q),
    .wdata (gtlb_pkg::tlb_entry_t'(hwdata[`TE_W-1:0])),
    .ridx  (tlb_sel_q),
    .req   (inv),
    .rdata (tlb_rdata)
  );

  guest_cp0_mem u_cp0 (
    .clk   (hclk),
    .we    (cp_we),
    .waddr (cp_waddr),
    .wdata (gpr_q),
    .raddr (cp0_sel_q),
    .rdata (cp_rdata)
  );

  // read mux
  always_comb begin
    rd_c = '0;
    unique case (haddr[`ADDRW-1:0])
      `OFF_CTRL:   rd_c = ctrl_q;
      `OFF_EHI:    rd_c[`ASIDW-1:0] = address_space_id_q;
      `OFF_INDEX:  rd_c[`IDXW-1:0] = idx_q;
      `OFF_GPRLO:  rd_c = gpr_q[31:0];
      `OFF_GPRHI:  rd_c = gpr_q[`CPDW-1:32];
      `OFF_INSTR:  rd_c = instr_q;
      `OFF_STATUS: begin
        rd_c[`ST_BUSY]  = state_q == gtlb_pkg::ST_EXEC;
        rd_c[`ST_EXC]   = exc_q;
        rd_c[`ST_GUEST] = exc_guest_q;
      end
      `OFF_TSEL:   rd_c[`IDXW-1:0] = tlb_sel_q;
      `OFF_TRDATA: rd_c[`TE_W-1:0] = tlb_rdata;
      `OFF_CSEL:   rd_c[`CPAW-1:0] = cp0_sel_q;
      `OFF_CRLO:   rd_c = cp_rdata[31:0];
      `OFF_CRHI:   rd_c = cp_rdata[`CPDW-1:32];
      default:     rd_c = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
      hresp  <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata <= rd_c;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_cpu_unusable: assert property (
    (state_q == gtlb_pkg::ST_EXEC && !ctrl_q[`CTRL_CP0EN])
    |-> !inv.go && !cp_we ##1 exc_q == `EXC_CPU)
    else $error("disabled coprocessor did not raise unusable");
  a_guest_ri: assert property (
    (state_q == gtlb_pkg::ST_EXEC && ctrl_q[`CTRL_CP0EN] && ctrl_q[`CTRL_GK])
    |-> !cp_we ##1 (exc_q == `EXC_RI && exc_guest_q))
    else $error("guest-kernel use not refused in guest mode");
  a_mtgc_copy: assert property (
    (state_q == gtlb_pkg::ST_EXEC && exc_d == `EXC_NONE && is_mtgc(instr_q))
    |-> cp_we ##1 u_cp0.mem_q[{instr_q[`I_RD], instr_q[`I_SEL]}] == gpr_q)
    else $error("guest register write missing");
  a_decode_inv: assert property (
    (state_q == gtlb_pkg::ST_EXEC && exc_d == `EXC_NONE && instr_q == `GINV_WORD)
    |-> inv.go && !inv.flush)
    else $error("address_space_id invalidate not decoded");
  a_joint_tlb_array_all: assert property (
    (inv.go && mt == `MT_JOINT) |-> (inv.lo == '0 && inv.hi == `IDXW'(`NENT - 1)))
    else $error("joint tlb range not whole array");
  a_hw_walk: assert property (
    (inv.go && mt == `MT_VF && ie == `IE_HW) |-> (inv.lo == '0 && inv.hi == `IDXW'(`NENT - 1)))
    else $error("hardware walk range not whole array");
  a_fixed_page_tlb_set: assert property (
    (inv.go && mt == `MT_VF && ie != `IE_HW && idx_q >= `IDXW'(`VSIZE))
    |-> (inv.hi - inv.lo == `IDXW'(`FWAYS - 1) && inv.lo <= idx_q && idx_q <= inv.hi))
    else $error("fixed-page set range wrong");
  a_no_tlb_ri: assert property (
    (state_q == gtlb_pkg::ST_EXEC && ctrl_q[`CTRL_CP0EN] && !ctrl_q[`CTRL_GK]
     && ctrl_q[`CTRL_VZ] && (dec_inv || dec_invf) && !tlb_ok) |=> exc_q == `EXC_RI)
    else $error("invalidate without guest tlb not refused");
  a_exec_stall: assert property (
    (state_q == gtlb_pkg::ST_IDLE && wr_pend_q && hreadyout && addr_q == `OFF_INSTR)
    |=> (!hreadyout && state_q == gtlb_pkg::ST_EXEC) ##1 (hreadyout && state_q == gtlb_pkg::ST_IDLE))
    else $error("bus not stalled during execute");
endmodule : guest_tlb_invalidate_and_cp0_write

// file: testbench/guest_tlb_invalidate_and_cp0_write_tb_top.sv
// self-checking bench for the guest tlb invalidate and guest cp0 write block
`include "gtlb_map.svh"
module guest_tlb_invalidate_and_cp0_write_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  logic [31:0] r;
  logic        sw_walk     = 1'b0;

  assign hready = hreadyout;

  guest_tlb_invalidate_and_cp0_write i_guest_tlb_invalidate_and_cp0_write (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata)
  );

  initial begin
    forever #12.5 hclk = ~hclk;
  end

  task end_of_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t timeout", $time);
      end_of_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one single ahb-lite transfer, address phase then data phase
  task ahb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr_en;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : ahb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    ahb(1'b1, a, d, dummy);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    ahb(1'b0, a, 32'h0, d);
  endtask : rd

  function automatic logic [31:0] mk(logic [2:0] mt, logic [1:0] ie, logic g1,
                                     logic [7:0] rid, logic en, logic gk,
                                     logic vz, logic tlb);
    return {8'h00, rid, 6'h00, ie, mt, tlb, g1, vz, gk, en};
  endfunction : mk

  // entry pattern: odd entries share the target address_space_id, every eighth is global
  function automatic logic [31:0] pat(int i);
    logic [7:0] address_space_id;
    logic [7:0] gid;
    address_space_id = (i % 2 == 1) ? 8'h5a : 8'h11;
    gid  = (i % 4 == 1) ? 8'h07 : 8'h02;
    return {14'h0, 1'b0, (i % 8 == 3) ? 1'b1 : 1'b0, gid, address_space_id};
  endfunction : pat

  task inv_case(input logic [2:0] mt, input logic [1:0] ie, input logic g1,
                input logic [7:0] rid, input logic [4:0] idx, input logic fl,
                input int lo, input int hi);
    logic [31:0] e;
    logic        hit;
    wr(`OFF_CTRL, mk(mt, ie, g1, rid, 1'b1, 1'b0, 1'b1, 1'b1));
    wr(`OFF_EHI, 32'h5a);
    wr(`OFF_INDEX, {27'h0, idx});
    for (int i = 0; i < `NENT; i++) begin
      wr(`OFF_TSEL, i);
      wr(`OFF_TWDATA, pat(i));
    end
    wr(`OFF_INSTR, fl ? {`OPC_SYSCTL, 1'b1, `Z19, `FN_GINVF} : `GINV_WORD);
    for (int s = `VSIZE; sw_walk && s < `NENT; s += `FWAYS) begin
      wr(`OFF_INDEX, s);
      wr(`OFF_INSTR, fl ? {`OPC_SYSCTL, 1'b1, `Z19, `FN_GINVF} : `GINV_WORD);
    end
    rd(`OFF_STATUS, r);
    chk(r, 32'h0);
    for (int i = 0; i < `NENT; i++) begin
      e   = pat(i);
      hit = (i >= lo) && (i <= hi) && (fl || (e[7:0] == 8'h5a && !e[16]))
            && (!g1 || e[15:8] == rid);
      wr(`OFF_TSEL, i);
      @(posedge hclk);
      rd(`OFF_TRDATA, r);
      chk(r, e | {14'h0, hit, 17'h0});
    end
  endtask : inv_case

  task exc_case(input logic [31:0] ctrl, input logic [31:0] instr,
                input logic [1:0] exc, input logic gst);
    wr(`OFF_CTRL, ctrl);
    wr(`OFF_INSTR, instr);
    rd(`OFF_STATUS, r);
    chk(r, {28'h0, gst, exc, 1'b0});
  endtask : exc_case

  task mtgc(input logic [4:0] rdn, input logic [2:0] sel, input logic [63:0] v);
    wr(`OFF_GPRLO, v[31:0]);
    wr(`OFF_GPRHI, v[63:32]);
    wr(`OFF_INSTR, {`OPC_SYSCTL, `RS_MTGC, 5'h00, rdn, `MTGC_SUB, sel});
  endtask : mtgc

  task cp0_chk(input logic [4:0] rdn, input logic [2:0] sel, input logic [63:0] v);
    wr(`OFF_CSEL, {24'h0, rdn, sel});
    @(posedge hclk);
    rd(`OFF_CRLO, r);
    chk(r, v[31:0]);
    rd(`OFF_CRHI, r);
    chk(r, v[63:32]);
  endtask : cp0_chk

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`OFF_CTRL, r);
    chk(r, `CTRL_RST);
    wr(`OFF_CTRL, 32'hffff_ffff);
    rd(`OFF_CTRL, r);
    chk(r, `CTRL_MASK);
    wr(8'h40, 32'h1234_5678);
    rd(8'h40, r);
    chk(r, 32'h0);
    wr(`OFF_CTRL, `CTRL_RST);
    mtgc(5'd9, 3'd0, 64'h0123_4567_89ab_cdef);
    mtgc(5'd12, 3'd2, 64'hfedc_ba98_7654_3210);
    cp0_chk(5'd9, 3'd0, 64'h0123_4567_89ab_cdef);
    cp0_chk(5'd12, 3'd2, 64'hfedc_ba98_7654_3210);
    wr(`OFF_CTRL, mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b0, 1'b0, 1'b1, 1'b1));
    mtgc(5'd9, 3'd0, 64'h5555_aaaa_5555_aaaa);
    rd(`OFF_STATUS, r);
    chk(r, {28'h0, 1'b0, `EXC_CPU, 1'b0});
    cp0_chk(5'd9, 3'd0, 64'h0123_4567_89ab_cdef);
    exc_case(mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b0, 1'b0, 1'b1, 1'b1), `GINV_WORD,
             `EXC_CPU, 1'b0);
    exc_case(mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b1, 1'b1, 1'b1, 1'b1),
             {`OPC_SYSCTL, `RS_MTGC, 5'h00, 5'd9, `MTGC_SUB, 3'd0}, `EXC_RI, 1'b1);
    exc_case(mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b1, 1'b0, 1'b1, 1'b0), `GINV_WORD,
             `EXC_RI, 1'b0);
    exc_case(mk(3'h4, 2'h0, 1'b0, 8'h0, 1'b1, 1'b0, 1'b1, 1'b1), `GINV_WORD,
             `EXC_RI, 1'b0);
    exc_case(mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b1, 1'b0, 1'b1, 1'b1), 32'h4200_100b,
             `EXC_RI, 1'b0);
    exc_case(mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b1, 1'b0, 1'b1, 1'b1), 32'h8200_000b,
             `EXC_RI, 1'b0);
    exc_case(mk(3'h4, 2'h3, 1'b0, 8'h0, 1'b1, 1'b0, 1'b1, 1'b1), `GINV_WORD,
             `EXC_NONE, 1'b0);
    inv_case(3'h1, 2'h2, 1'b0, 8'h00, 5'd20, 1'b0, 0, 31);
    inv_case(3'h4, 2'h2, 1'b0, 8'h00, 5'd3, 1'b0, 0, 15);
    inv_case(3'h4, 2'h2, 1'b0, 8'h00, 5'd21, 1'b0, 20, 23);
    sw_walk = 1'b1;
    inv_case(3'h4, 2'h2, 1'b0, 8'h00, 5'd3, 1'b0, 0, 31);
    sw_walk = 1'b0;
    inv_case(3'h4, 2'h3, 1'b0, 8'h00, 5'd21, 1'b0, 0, 31);
    inv_case(3'h4, 2'h3, 1'b1, 8'h07, 5'd0, 1'b0, 0, 31);
    inv_case(3'h1, 2'h2, 1'b0, 8'h00, 5'd5, 1'b1, 0, 31);
    inv_case(3'h4, 2'h2, 1'b0, 8'h00, 5'd9, 1'b1, 0, 15);
    inv_case(3'h4, 2'h2, 1'b0, 8'h00, 5'd31, 1'b1, 28, 31);
    inv_case(3'h4, 2'h2, 1'b1, 8'h02, 5'd17, 1'b1, 16, 19);
    end_of_test();
  end
endmodule : guest_tlb_invalidate_and_cp0_write_tb_top
